/* File: core/isspi_defs.vh */
// constants for the inertial sensor spi slave port
`ifndef ISSPI_DEFS_VH
`define ISSPI_DEFS_VH
`define ISSPI_FRAME_BITS 16
`define ISSPI_CNT_W 4
`define ISSPI_RW_BIT 15
`define ISSPI_ADDR_HI 14
`define ISSPI_ADDR_LO 8
`define ISSPI_NREGS 64
`define ISSPI_FLASH_WRITE_COUNTER_ADDR 7'h00
`define ISSPI_X_ACCEL_OUTPUT_ADDR 7'h0A
`define ISSPI_SAMPLE_PERIOD_FIELD_ADDR 7'h36
`define ISSPI_GLOBAL_COMMAND_REG_ADDR 7'h3E
`define ISSPI_BACKUP_BIT 3
`define ISSPI_SAMPLE_PERIOD_FIELD_RST 16'h0001
`define ISSPI_CLK_HZ 125000000
`define ISSPI_BACKUP_MS 50
`define ISSPI_BACKUP_CYC ((`ISSPI_CLK_HZ / 1000) * `ISSPI_BACKUP_MS)
`define ISSPI_SAMPLE_MHZ_X10 8192
`define ISSPI_SAMPLE_CYC ((`ISSPI_CLK_HZ * 10) / `ISSPI_SAMPLE_MHZ_X10)
`define ISSPI_DRDY_CYC 5'h10
`endif

/* File: core/isspi_port.v */
// spi slave register access port of an inertial sensor
`timescale 1ns/100ps
`include "isspi_defs.vh"

// Operation
// RULE1: device is spi slave; master drives clock, select, starts transfers.
// RULE2: mode 3: clock idles high, capture on rising edge.
// RULE3: sixteen bit frames, msb first, both directions.
// RULE4: serial-out changes on each falling clock edge.
// RULE5: serial-in sampled on each rising clock edge.
// RULE6: read request: top bit zero, seven bit address, low byte ignored.
// RULE7: next frame returns all sixteen bits of addressed register.
// RULE8: full duplex: next command accepted while previous data returns.
// RULE9: top bit one writes low byte to addressed byte at frame end.
// RULE10: each register spans two byte addresses, upper and lower.
// RULE11: global command bit three starts 50 ms flash backup.
// RULE12: flash write counter increments on each backup.
// RULE13: after each sample, load output registers and pulse data ready.
// RULE14: sampling starts alone after reset at 819.2 samples per second.
// RULE15: master limits serial clock rate by mode.
// RULE16: frame after a write returns undefined data.
// RULE17: select high between frames resets bit counter.
module isspi_port #(
  parameter BACKUP_CYC = `ISSPI_BACKUP_CYC,
  parameter SAMPLE_CYC = `ISSPI_SAMPLE_CYC
)(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_din,
  input wire [15:0] i_x_accel_sample,
  output reg o_dout,
  output reg o_data_ready_pin,
  output reg o_backup_busy,
  output reg [15:0] o_sample_period_field
);

function [5:0] reg_index;
  input [6:0] byte_addr;
  begin
    reg_index = byte_addr[6:1];
  end
endfunction

// odd byte address is the upper half of the word
function [15:0] merge_byte;
  input [15:0] old_word;
  input upper;
  input [7:0] value;
  begin
    if (upper)
      merge_byte = {value, old_word[7:0]};
    else
      merge_byte = {old_word[15:8], value};
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [1:0] sclk_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] din_sync_reg;
reg sclk_prev_reg;
reg cs_prev_reg;
// clock and select reset to their idle high level: no false edge after reset
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    sclk_sync_reg <= 2'h3;
    sclk_prev_reg <= 1'h1;
  end
  else
  begin
    sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
    sclk_prev_reg <= sclk_sync_reg[1];
  end
end

always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    cs_sync_reg <= 2'h3;
    cs_prev_reg <= 1'h1;
  end
  else
  begin
    cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
    cs_prev_reg <= cs_sync_reg[1];
  end
end

always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
    din_sync_reg <= 2'h0;
  else
    din_sync_reg <= {din_sync_reg[0], i_din};
end

wire sclk_s = sclk_sync_reg[1];
wire cs_n_s = cs_sync_reg[1];
wire din_s = din_sync_reg[1];
// edges only count while selected
wire sclk_rise = sclk_s & ~sclk_prev_reg & ~cs_n_s; // RULE2
wire sclk_fall = ~sclk_s & sclk_prev_reg & ~cs_n_s; // RULE1
wire cs_fall = ~cs_n_s & cs_prev_reg;

////////////////////////////////////////////////////////////////////////////
// register store and frame engine
reg [15:0] regs_reg [0:`ISSPI_NREGS-1];
reg [15:0] rx_reg;
reg [15:0] tx_reg;
reg [3:0] bit_cnt_reg;
reg frame_done_reg;
reg [15:0] frame_word_reg;
reg [31:0] backup_cnt_reg;
reg [31:0] sample_cnt_reg;
reg [4:0] drdy_cnt_reg;
reg [15:0] flash_write_counter_reg;
reg [15:0] xaccl_reg;
reg [15:0] reply_reg;

wire [15:0] rx_next = {rx_reg[14:0], din_s};
wire [6:0] fr_addr = frame_word_reg[`ISSPI_ADDR_HI:`ISSPI_ADDR_LO];
wire fr_write = frame_word_reg[`ISSPI_RW_BIT];
wire backup_go = frame_done_reg & fr_write & (fr_addr == `ISSPI_GLOBAL_COMMAND_REG_ADDR) &
  frame_word_reg[`ISSPI_BACKUP_BIT];

// read source selection; live state registers override the store
always @*
begin
  case (reg_index(fr_addr)) // RULE10
    reg_index(`ISSPI_FLASH_WRITE_COUNTER_ADDR): reply_reg = flash_write_counter_reg;
    reg_index(`ISSPI_X_ACCEL_OUTPUT_ADDR): reply_reg = xaccl_reg;
    reg_index(`ISSPI_SAMPLE_PERIOD_FIELD_ADDR): reply_reg = o_sample_period_field;
    default: reply_reg = regs_reg[reg_index(fr_addr)];
  endcase
end

integer k;
// receive side; counter wraps so back-to-back frames stay aligned
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    rx_reg <= 16'h0000;
    bit_cnt_reg <= 4'h0;
    frame_done_reg <= 1'h0;
    frame_word_reg <= 16'h0000;
  end
  else
  begin
    frame_done_reg <= 1'h0;
    if (cs_n_s | cs_fall)
      bit_cnt_reg <= 4'h0; // RULE17
    else if (sclk_rise)
    begin
      rx_reg <= rx_next; // RULE5 RULE3
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == 4'hF)
      begin
        frame_done_reg <= 1'h1;
        frame_word_reg <= rx_next;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// transmit side: shift only on falling edges after the first of a frame, one bit per edge
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
    tx_reg <= 16'h0000;
  else if (frame_done_reg)
  begin
    if (!fr_write)
      tx_reg <= reply_reg; // RULE6 RULE7 RULE8
    else
      tx_reg <= 16'h0000; // RULE16
  end
  else if (sclk_fall && bit_cnt_reg != 4'h0)
    tx_reg <= {tx_reg[14:0], 1'h0};
end

// first bit leaves at select fall, each later bit at a falling edge
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
    o_dout <= 1'h0;
  else if (cs_fall)
    o_dout <= tx_reg[15];
  else if (sclk_fall)
  begin
    if (bit_cnt_reg == 4'h0)
      o_dout <= tx_reg[15];
    else
      o_dout <= tx_reg[14]; // RULE4
  end
end

////////////////////////////////////////////////////////////////////////////
// byte store, written only when a whole frame has arrived
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    for (k = 0; k < `ISSPI_NREGS; k = k + 1)
      regs_reg[k] <= 16'h0000;
  end
  else if (frame_done_reg && fr_write)
  begin
    regs_reg[reg_index(fr_addr)] <= // RULE9
      merge_byte(regs_reg[reg_index(fr_addr)], fr_addr[0], frame_word_reg[7:0]); // RULE10
  end
end

////////////////////////////////////////////////////////////////////////////
// sample period control
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
    o_sample_period_field <= `ISSPI_SAMPLE_PERIOD_FIELD_RST;
  else if (frame_done_reg && fr_write &&
    reg_index(fr_addr) == reg_index(`ISSPI_SAMPLE_PERIOD_FIELD_ADDR))
    o_sample_period_field <=
      merge_byte(o_sample_period_field, fr_addr[0], frame_word_reg[7:0]);
end

////////////////////////////////////////////////////////////////////////////
// flash backup
wire backup_done = o_backup_busy & (backup_cnt_reg == BACKUP_CYC - 1);
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    o_backup_busy <= 1'h0;
    backup_cnt_reg <= 32'h00000000;
  end
  else if (o_backup_busy)
  begin
    if (backup_done)
      o_backup_busy <= 1'h0;
    backup_cnt_reg <= backup_cnt_reg + 32'h00000001;
  end
  else if (backup_go)
  begin
    // command while busy is dropped: one copy is already in flight
    o_backup_busy <= 1'h1; // RULE11
    backup_cnt_reg <= 32'h00000000;
  end
end

// counts finished copies only
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
    flash_write_counter_reg <= 16'h0000;
  else if (backup_done)
    flash_write_counter_reg <= flash_write_counter_reg + 16'h0001; // RULE12
end

////////////////////////////////////////////////////////////////////////////
// autonomous sampling; period scaled by the low byte of the period field
wire sample_tick = (sample_cnt_reg >=
  SAMPLE_CYC * {24'h000000, o_sample_period_field[7:0]} - 32'h00000001);
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    sample_cnt_reg <= 32'h00000000;
    xaccl_reg <= 16'h0000;
  end
  else if (sample_tick)
  begin
    sample_cnt_reg <= 32'h00000000; // RULE14
    xaccl_reg <= i_x_accel_sample; // RULE13
  end
  else
    sample_cnt_reg <= sample_cnt_reg + 32'h00000001;
end

// pulse held for a fixed count so a slow interrupt input still sees it
always @(posedge i_clk_sys or posedge i_rst)
begin
  if (i_rst)
  begin
    o_data_ready_pin <= 1'h0;
    drdy_cnt_reg <= 5'h00;
  end
  else if (sample_tick)
  begin
    o_data_ready_pin <= 1'h1; // RULE13
    drdy_cnt_reg <= `ISSPI_DRDY_CYC;
  end
  else if (drdy_cnt_reg != 5'h00)
    drdy_cnt_reg <= drdy_cnt_reg - 5'h01;
  else
    o_data_ready_pin <= 1'h0;
end

endmodule

/* File: test/isspi_master.sv */
// spi master model for the sensor port, mode 3, msb first
`timescale 1ns/100ps
module isspi_master (
  output logic o_sclk = 1'b1,
  output logic o_cs_n = 1'b1,
  output logic o_din = 1'b0,
  input wire logic i_dout
);
  // bench link rate is 8 MHz, above the real limit, to keep runs short
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    o_cs_n = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_din = w[i];
      #62.5;
      o_sclk = 1'b1;
      r[i] = i_dout;
      #62.5;
    end
    o_cs_n = 1'b1;
    o_din = ~o_din;
    #120;
  endtask
endmodule

/* File: test/isspi_properties.sv */
// concurrent checks on the sensor spi port pins
`timescale 1ns/100ps
module isspi_properties #(
  parameter BACKUP_CYC = 100
)(
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_sclk,
  input wire i_cs_n,
  input wire o_dout,
  input wire o_data_ready_pin,
  input wire o_backup_busy,
  input wire [15:0] o_sample_period_field
);
  reg [31:0] busy_cnt_reg;
  always @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= o_backup_busy ? busy_cnt_reg + 32'h1 : 32'h0;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_reset_values: assert property ($fell(i_rst) |->
    o_sample_period_field == 16'h0001 && !o_backup_busy) else $error("bad reset value");
  // five cycles leave room for the two-flop delay after a select fall
  a_dout_steady: assert property ((i_sclk && !i_cs_n)[*5] |=> $stable(o_dout))
    else $error("dout moved while clock high");
  a_ready_width: assert property ($rose(o_data_ready_pin) |-> o_data_ready_pin[*8])
    else $error("ready pulse short");
  a_ready_ends: assert property ($rose(o_data_ready_pin) |-> ##[9:30] !o_data_ready_pin)
    else $error("ready pulse stuck");
  a_sample_rate: assert property ($rose(o_data_ready_pin) && o_sample_period_field == 16'h0001
    |-> ##[45:55] ($rose(o_data_ready_pin) || o_sample_period_field != 16'h0001))
    else $error("sample interval wrong");
  a_backup_len: assert property ($fell(o_backup_busy) |-> busy_cnt_reg == BACKUP_CYC)
    else $error("backup length wrong");
  a_write_end: assert property ($changed(o_sample_period_field) |-> i_sclk)
    else $error("write outside frame end");
  a_backup_start: assert property ($rose(o_backup_busy) |-> i_sclk)
    else $error("backup outside frame end");
endmodule
bind isspi_port isspi_properties #(.BACKUP_CYC(BACKUP_CYC)) u_props (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_dout(o_dout),
  .o_data_ready_pin(o_data_ready_pin), .o_backup_busy(o_backup_busy),
  .o_sample_period_field(o_sample_period_field));

/* File: test/tb.sv */
// self-checking bench for the sensor spi port
`timescale 1ns/100ps
module tb;
  reg i_clk_sys = 1'b0;
  reg i_rst = 1'b1;
  reg [15:0] xs = 16'h1234;
  wire sclk, cs_n, din, dout, drdy, busy;
  wire [15:0] prd;
  logic [15:0] rx;
  integer err_count = 0;
  integer checks = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  isspi_master m (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
  isspi_port #(.BACKUP_CYC(100), .SAMPLE_CYC(50)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .i_x_accel_sample(xs), .o_dout(dout),
    .o_data_ready_pin(drdy), .o_backup_busy(busy), .o_sample_period_field(prd));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks = checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_sample;
    for (int n = 0; n < 500 && drdy !== 1'b1; n++)
    begin
      @(posedge i_clk_sys);
      #1;
    end
    chk("ready", 16'h0001, {15'h0, drdy});
  endtask
  task t_read;
    m.xfer(16'h0AFF, rx);
    m.xfer(16'h0B00, rx);
    chk("x_accel", 16'h1234, rx);
    m.xfer(16'h0000, rx);
    chk("x_accel_odd", 16'h1234, rx);
  endtask
  task t_write;
    m.xfer(16'hB602, rx);
    chk("period_lo", 16'h0002, prd);
    m.xfer(16'hB712, rx);
    chk("period_hi", 16'h1202, prd);
    m.xfer(16'h3600, rx);
    m.xfer(16'hB601, rx);
    chk("period_rd", 16'h1202, rx);
    m.xfer(16'hB700, rx);
    chk("period_back", 16'h0001, prd);
  endtask
  task t_backup;
    m.xfer(16'hBE08, rx);
    chk("busy_on", 16'h0001, {15'h0, busy});
    repeat (110) @(posedge i_clk_sys);
    #1;
    chk("busy_off", 16'h0000, {15'h0, busy});
    m.xfer(16'h0000, rx);
    m.xfer(16'h0000, rx);
    chk("flash_count", 16'h0001, rx);
  endtask
  initial
  begin
    #150000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (10) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    chk("period_rst", 16'h0001, prd);
    chk("busy_rst", 16'h0000, {15'h0, busy});
    t_sample;
    t_read;
    t_write;
    t_backup;
    tally_and_finish;
  end
endmodule
